/* logic/spm_pkg.sv */
// Constants and types for the shared pin multiplexer.
// Assumes one system clock; the owning units live on that same clock.
package spm_pkg;

   localparam int PIN_COUNT      = 16;
   localparam int VECTOR_W       = 4;
   localparam int GPIO_HALF_W    = 4;
   localparam int HOST_W         = 12;
   localparam int SERIAL_W       = 8;
   localparam int IOC_W          = 16;

   // Selection bits inside the I/O configuration register.
   localparam int IOC_UPPER_SEL_BIT  = 12;
   localparam int IOC_SERIAL_SEL_BIT = 10;

   // Pin field positions.
   localparam int UPPER_GRP_LO   = 0;
   localparam int LOWER_GRP_LO   = 4;
   localparam int LOWER_GPIO_LO  = 4;
   localparam int SERIAL_LO      = 8;

   // Reset values.
   localparam logic [VECTOR_W-1:0]  VECTOR_OE_ON = 4'hF;
   localparam logic [VECTOR_W-1:0]  VECTOR_RESET = 4'h0;
   localparam logic [HOST_W-1:0]    HOST_RESET   = 12'h000;
   localparam logic [PIN_COUNT-1:0] PIN_RESET = 16'h0000;

   typedef enum logic {
      SPM_UPPER_VECTOR = 1'b0,
      SPM_UPPER_GPIO = 1'b1
   } spm_upper_owner_t;

   typedef enum logic {
      SPM_LOWER_HOST   = 1'b0,
      SPM_LOWER_SERIAL = 1'b1
   } spm_lower_owner_t;

endpackage

/* logic/spm_sync.sv */
// Two-flop synchroniser for a bus of independent pin levels.
// Assumes each bit is a slow level; no bus coherency is promised.
`timescale 1ns/1ps
`default_nettype none
module spm_sync #(
   parameter int W = 16
) (
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] stage1;
   logic [W-1:0] next_stage1;
   logic [W-1:0] next_sync_out;

   always_comb begin
      next_stage1   = async_in;
      next_sync_out = stage1;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage1   <= '0;
         sync_out <= '0;
      end else begin
         stage1   <= next_stage1;
         sync_out <= next_sync_out;
      end
   end

endmodule
`default_nettype wire

/* logic/spm_pin_mux.sv */
// Shared pin multiplexer: hands 16 package pins between internal units.
// Assumes the configuration word and unit signals come from logic on clk,
// and the pins are resolved outside from pin_out and pin_oe.
`timescale 1ns/1ps
`default_nettype none

module spm_pin_mux (
   input  wire logic                            clk,
   input  wire logic                            reset_n,
   input  wire logic [spm_pkg::IOC_W-1:0]       io_config,
   input  wire logic [spm_pkg::VECTOR_W-1:0]    irq_vector_code_out,
   input  wire logic [spm_pkg::GPIO_HALF_W-1:0] upper_gpio_bits_out,
   input  wire logic [spm_pkg::GPIO_HALF_W-1:0] upper_gpio_bits_oe,
   output logic      [spm_pkg::GPIO_HALF_W-1:0] upper_gpio_bits_in,
   input  wire logic [spm_pkg::GPIO_HALF_W-1:0] lower_gpio_bits_out,
   input  wire logic [spm_pkg::GPIO_HALF_W-1:0] lower_gpio_bits_oe,
   output logic      [spm_pkg::GPIO_HALF_W-1:0] lower_gpio_bits_in,
   input  wire logic [spm_pkg::HOST_W-1:0]      parallel_host_port_out,
   input  wire logic [spm_pkg::HOST_W-1:0]      parallel_host_port_oe,
   output logic      [spm_pkg::HOST_W-1:0]      parallel_host_port_in,
   input  wire logic [spm_pkg::SERIAL_W-1:0]    second_serial_port_out,
   input  wire logic [spm_pkg::SERIAL_W-1:0]    second_serial_port_oe,
   output logic      [spm_pkg::SERIAL_W-1:0]    second_serial_port_in,
   input  wire logic [spm_pkg::PIN_COUNT-1:0]   pin_in,
   output logic      [spm_pkg::PIN_COUNT-1:0]   pin_out,
   output logic      [spm_pkg::PIN_COUNT-1:0]   pin_oe,
   output logic                                 upper_gpio_pin_select,
   output logic                                 second_serial_pin_select
);

   localparam int UL = spm_pkg::UPPER_GRP_LO;
   localparam int LL = spm_pkg::LOWER_GRP_LO;
   localparam int GL = spm_pkg::LOWER_GPIO_LO;
   localparam int SL = spm_pkg::SERIAL_LO;
   localparam int VW = spm_pkg::VECTOR_W;
   localparam int GW = spm_pkg::GPIO_HALF_W;
   localparam int PW = spm_pkg::HOST_W;
   localparam int SW = spm_pkg::SERIAL_W;
   localparam int UB = spm_pkg::IOC_UPPER_SEL_BIT;
   localparam int SB = spm_pkg::IOC_SERIAL_SEL_BIT;

   spm_pkg::spm_upper_owner_t upper_owner;
   spm_pkg::spm_upper_owner_t next_upper_owner;
   spm_pkg::spm_lower_owner_t lower_owner;
   spm_pkg::spm_lower_owner_t next_lower_owner;

   logic [spm_pkg::PIN_COUNT-1:0] pin_sync;
   logic [spm_pkg::PIN_COUNT-1:0] next_pin_out;
   logic [spm_pkg::PIN_COUNT-1:0] next_pin_oe;
   logic [GW-1:0]                 next_upper_in;
   logic [GW-1:0]                 next_lower_in;
   logic [PW-1:0]                 next_host_in;
   logic [SW-1:0]                 next_serial_in;

   // Pin levels come from outside the clock domain.
   spm_sync #(
      .W (spm_pkg::PIN_COUNT)
   ) u_pin_sync (
      .clk      (clk),
      .reset_n  (reset_n),
      .async_in (pin_in),
      .sync_out (pin_sync)
   );

   always_comb begin
      case (io_config[spm_pkg::IOC_UPPER_SEL_BIT])
         1'b1:    next_upper_owner = spm_pkg::SPM_UPPER_GPIO;
         default: next_upper_owner = spm_pkg::SPM_UPPER_VECTOR;
      endcase
      case (io_config[spm_pkg::IOC_SERIAL_SEL_BIT])
         1'b1:    next_lower_owner = spm_pkg::SPM_LOWER_SERIAL;
         default: next_lower_owner = spm_pkg::SPM_LOWER_HOST;
      endcase
   end

   // The pin drivers are built from the next owner so that a select change
   // moves drive and owner on the same edge; a single mux per pin means two
   // units can never drive one pin, even in the switching cycle.
   // One owner per pin
   always_comb begin
      next_pin_out  = spm_pkg::PIN_RESET;
      next_pin_oe   = spm_pkg::PIN_RESET;
      next_upper_in = '0;
      next_lower_in = '0;
      next_host_in  = '0;
      next_serial_in = '0;
      case (next_upper_owner)
         spm_pkg::SPM_UPPER_GPIO: begin
            next_pin_out[UL +: GW] = upper_gpio_bits_out;
            next_pin_oe[UL +: GW]  = upper_gpio_bits_oe;
            next_upper_in          = pin_sync[UL +: GW];
         end
         default: begin
            next_pin_out[UL +: VW] = irq_vector_code_out;
            next_pin_oe[UL +: VW]  = spm_pkg::VECTOR_OE_ON;
         end
      endcase
      case (next_lower_owner)
         spm_pkg::SPM_LOWER_SERIAL: begin
            next_pin_out[GL +: GW] = lower_gpio_bits_out;
            next_pin_oe[GL +: GW]  = lower_gpio_bits_oe;
            next_lower_in          = pin_sync[GL +: GW];
            next_pin_out[SL +: SW] = second_serial_port_out;
            next_pin_oe[SL +: SW]  = second_serial_port_oe;
            next_serial_in         = pin_sync[SL +: SW];
         end
         default: begin
            next_pin_out[LL +: PW] = parallel_host_port_out;
            next_pin_oe[LL +: PW]  = parallel_host_port_oe;
            next_host_in           = pin_sync[LL +: PW];
         end
      endcase
   end

   // Reset leaves vectors driving low and the host port released.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         upper_owner           <= spm_pkg::SPM_UPPER_VECTOR;
         lower_owner           <= spm_pkg::SPM_LOWER_HOST;
         pin_out               <= spm_pkg::PIN_RESET;
         pin_oe                <= {{(spm_pkg::PIN_COUNT-VW){1'b0}},
                                   spm_pkg::VECTOR_OE_ON};
         upper_gpio_bits_in    <= '0;
         lower_gpio_bits_in    <= '0;
         parallel_host_port_in <= spm_pkg::HOST_RESET;
         second_serial_port_in <= '0;
      end else begin
         upper_owner           <= next_upper_owner;
         lower_owner           <= next_lower_owner;
         pin_out               <= next_pin_out;
         pin_oe                <= next_pin_oe;
         upper_gpio_bits_in    <= next_upper_in;
         lower_gpio_bits_in    <= next_lower_in;
         parallel_host_port_in <= next_host_in;
         second_serial_port_in <= next_serial_in;
      end
   end

   always_comb begin
      upper_gpio_pin_select    = (upper_owner == spm_pkg::SPM_UPPER_GPIO);
      second_serial_pin_select = (lower_owner == spm_pkg::SPM_LOWER_SERIAL);
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // The pin round trip is two synchroniser flops plus the input register.
   property p_pin_to_serial;
      io_config[SB] [*4] |->
         second_serial_port_in == $past(pin_in[SL +: SW], 3);
   endproperty
   a_pin_to_serial: assert property (p_pin_to_serial)
      else $error("serial unit input does not follow its pins");

   property p_pin_to_upper;
      io_config[UB] [*4] |->
         upper_gpio_bits_in == $past(pin_in[UL +: GW], 3);
   endproperty
   a_pin_to_upper: assert property (p_pin_to_upper)
      else $error("upper gpio input does not follow its pins");

   property p_vector_routed;
      !io_config[UB] |=> pin_out[UL +: VW] == $past(irq_vector_code_out)
         && pin_oe[UL +: VW] == spm_pkg::VECTOR_OE_ON
         && upper_gpio_bits_in == 4'h0;
   endproperty
   a_vector_routed: assert property (p_vector_routed)
      else $error("vector code not on pins 3:0");

   property p_upper_gpio;
      io_config[UB] |=> pin_out[UL +: GW] == $past(upper_gpio_bits_out)
         && pin_oe[UL +: GW] == $past(upper_gpio_bits_oe)
         && upper_gpio_pin_select;
   endproperty
   a_upper_gpio: assert property (p_upper_gpio)
      else $error("upper gpio not on pins 3:0");

   property p_host_routed;
      !io_config[SB] |=> pin_oe[LL +: PW] == $past(parallel_host_port_oe)
         && pin_out[LL +: PW] == $past(parallel_host_port_out)
         && second_serial_port_in == 8'h00 && lower_gpio_bits_in == 4'h0;
   endproperty
   a_host_routed: assert property (p_host_routed)
      else $error("host port not on pins 15:4");

   property p_serial_routed;
      io_config[SB] |=> pin_out[SL +: SW] == $past(second_serial_port_out)
         && pin_out[GL +: GW] == $past(lower_gpio_bits_out)
         && pin_oe[SL +: SW] == $past(second_serial_port_oe)
         && pin_oe[GL +: GW] == $past(lower_gpio_bits_oe)
         && parallel_host_port_in == 12'h000;
   endproperty
   a_serial_routed: assert property (p_serial_routed)
      else $error("serial port and lower gpio not on pins 15:4");

   property p_lower_return;
      $fell(io_config[SB]) |=> !second_serial_pin_select
         && pin_oe[LL +: PW] == $past(parallel_host_port_oe);
   endproperty
   a_lower_return: assert property (p_lower_return)
      else $error("pins 15:4 not returned to host port");

   property p_upper_return;
      $fell(io_config[UB]) |=> !upper_gpio_pin_select
         && pin_oe[UL +: VW] == spm_pkg::VECTOR_OE_ON;
   endproperty
   a_upper_return: assert property (p_upper_return)
      else $error("pins 3:0 not returned to vector code");

   c_upper_switch: cover property ($rose(upper_gpio_pin_select));
   c_serial_switch: cover property ($rose(second_serial_pin_select));
   c_serial_data: cover property (
      second_serial_pin_select && second_serial_port_in != 8'h00);
   c_both_back: cover property (
      $fell(upper_gpio_pin_select) && $fell(second_serial_pin_select));

endmodule
`default_nettype wire

/* verification/spm_pin_partner.sv */
// Far-side model: external devices wired to the sixteen shared pins.
// Assumes the devices drive every pin that the multiplexer leaves released.
`timescale 1ns/1ps
`default_nettype none
module spm_pin_partner (
   input  wire logic [spm_pkg::PIN_COUNT-1:0] pin_out,
   input  wire logic [spm_pkg::PIN_COUNT-1:0] pin_oe,
   input  wire logic [spm_pkg::PIN_COUNT-1:0] ext_val,
   output logic      [spm_pkg::PIN_COUNT-1:0] pin_in
);
   // one driver per pin
   // A released pin shows what the outside device drives, never a held value.
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule
`default_nettype wire

/* verification/shared_pin_multiplexer_test.sv */
// Self-checking bench for the shared pin multiplexer.
// Assumes the partner model resolves the pins from pin_out and pin_oe.
`timescale 1ns/1ps
`default_nettype none
module shared_pin_multiplexer_test;
   logic        clk;
   logic        reset_n;
   logic [15:0] io_config;
   logic [15:0] pat;
   logic [15:0] ext_val;
   logic [3:0]  ug_in;
   logic [3:0]  lg_in;
   logic [11:0] ph_in;
   logic [7:0]  s_in;
   logic [15:0] pin_in;
   logic [15:0] pin_out;
   logic [15:0] pin_oe;
   logic        usel;
   logic        ssel;
   int          n_fail;
   int          tests_run;

   spm_pin_mux u_dut (
      .clk(clk), .reset_n(reset_n), .io_config(io_config),
      .irq_vector_code_out(pat[3:0]),
      .upper_gpio_bits_out(pat[7:4]), .upper_gpio_bits_oe(pat[11:8]),
      .upper_gpio_bits_in(ug_in),
      .lower_gpio_bits_out(~pat[3:0]), .lower_gpio_bits_oe(pat[15:12]),
      .lower_gpio_bits_in(lg_in),
      .parallel_host_port_out(pat[11:0]), .parallel_host_port_oe(~pat[11:0]),
      .parallel_host_port_in(ph_in),
      .second_serial_port_out(pat[15:8]), .second_serial_port_oe(~pat[7:0]),
      .second_serial_port_in(s_in),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .upper_gpio_pin_select(usel), .second_serial_pin_select(ssel));

   spm_pin_partner u_far (
      .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val), .pin_in(pin_in));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [15:0] seen,
                      input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic stop_test();
      if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic apply(input logic [15:0] cfg, input logic [15:0] p,
                        input logic [15:0] e);
      @(posedge clk);
      #1;
      io_config = cfg;
      pat       = p;
      ext_val   = e;
   endtask

   // Expectations follow the owner map; five edges cover the pin round trip.
   task automatic check_all();
      logic        u;
      logic        s;
      logic [15:0] oe;
      logic [15:0] out;
      logic [15:0] lvl;
      u   = io_config[12];
      s   = io_config[10];
      oe  = {s ? ~pat[7:0] : ~pat[11:4], s ? pat[15:12] : ~pat[3:0],
             u ? pat[11:8] : 4'hF};
      out = {s ? pat[15:8] : pat[11:4], s ? ~pat[3:0] : pat[3:0],
             u ? pat[7:4] : pat[3:0]};
      lvl = (oe & out) | (~oe & ext_val);
      repeat (5) @(posedge clk);
      #1;
      chk("pin_oe", pin_oe, oe);
      chk("pin_out", pin_out, out);
      chk("usel", {15'h0000, usel}, {15'h0000, u});
      chk("ssel", {15'h0000, ssel}, {15'h0000, s});
      chk("ug_in", {12'h000, ug_in}, {12'h000, u ? lvl[3:0] : 4'h0});
      chk("lg_in", {12'h000, lg_in}, {12'h000, s ? lvl[7:4] : 4'h0});
      chk("ph_in", {4'h0, ph_in}, s ? 16'h0000 : {4'h0, lvl[15:4]});
      chk("s_in", {8'h00, s_in}, s ? {8'h00, lvl[15:8]} : 16'h0000);
   endtask

   task automatic t_reset();
      repeat (2) @(posedge clk);
      #1;
      chk("rst_oe", pin_oe, 16'h000F);
      chk("rst_out", pin_out, 16'h0000);
      chk("rst_sel", {14'h0000, usel, ssel}, 16'h0000);
      chk("rst_in", {ug_in, lg_in, s_in}, 16'h0000);
   endtask

   task automatic t_default();
      apply(16'h0000, 16'hA5C3, 16'h5A3C);
      check_all();
   endtask

   task automatic t_upper();
      apply(16'h1000, 16'h3C96, 16'hF0E1);
      check_all();
   endtask

   // Select must follow the config bit at the very next edge.
   task automatic t_serial();
      apply(16'h0400, 16'h6B2D, 16'h0FF0);
      @(posedge clk);
      #1;
      chk("ssel_edge", {15'h0000, ssel}, 16'h0001);
      check_all();
   endtask

   // Both groups switched, then cleared with unrelated bits set.
   task automatic t_clear();
      apply(16'h1400, 16'hD21E, 16'hC3A5);
      check_all();
      apply(16'hEBFF, 16'h4E71, 16'h1E2D);
      check_all();
   endtask

   // A reset in mid-run drops both groups to their defaults at once.
   task automatic t_mid_reset();
      apply(16'h1400, 16'h9C63, 16'hFFFF);
      repeat (5) @(posedge clk);
      #1;
      reset_n = 1'b0;
      #1;
      chk("mid_oe", pin_oe, 16'h000F);
      chk("mid_out", pin_out, 16'h0000);
      chk("mid_sel", {14'h0000, usel, ssel}, 16'h0000);
      chk("mid_in", {ug_in, lg_in, s_in}, 16'h0000);
      chk("mid_ph", {4'h0, ph_in}, 16'h0000);
      repeat (3) @(posedge clk);
      #1;
      reset_n = 1'b1;
      @(posedge clk);
      #1;
      chk("mid_usel", {15'h0000, usel}, 16'h0001);
      check_all();
   endtask

   initial begin
      n_fail    = 0;
      tests_run = 0;
      reset_n   = 1'b0;
      io_config = 16'h0000;
      pat       = 16'h0000;
      ext_val   = 16'h0000;
      t_reset();
      @(posedge clk);
      #1;
      reset_n = 1'b1;
      t_default();
      t_upper();
      t_serial();
      t_clear();
      t_mid_reset();
      stop_test();
   end
endmodule
`default_nettype wire
